// ===== rtl/cll_cfg.svh
// Constants of the compare latch loader: offsets, field positions, reset values.
// Assumes a 16-bit timer count and at most seven compare channels.
// How it works
// R1 - Comparators look at the compare latch, never at the software-written buffer.
// R2 - Software writes buffers; hardware copies them to latches on the chosen load event.
// R3 - Load select 0 copies a buffer to its latch on every write, grouped or not.
// R4 - Load select 1 loads when the count is zero in count modes 1 to 3.
// R5 - Load select 2 loads at zero, or in up/down mode also at the period latch value.
// R6 - Load select 3 loads each latch when the count equals that latch, per channel.
// R7 - Group select 1 makes pairs 1-2,3-4,5-6; 2 makes triples 1-3,4-6; 3 groups all.
// R8 - A pair or triple takes its load select from its lowest-numbered channel.
// R9 - With all seven grouped, channel 1's load select governs every latch.
// R10 - A grouped load under load select 1 or 2 needs every group buffer written since the last load.
// R11 - Software rewrites unchanged values; a write of identical data counts as an update.
// R12 - Under load select 1 or 2, all latches of a group load on the same clock edge.
// R13 - Each pair or triple runs independently with the load select of its own lowest channel.
// R14 - With three channels, group select 2 acts as 1, and 3 groups channels 0 to 2.
// R15 - Count mode: 0 halted, 1 up to period, 2 continuous, 3 up/down.
// R16 - Group select sits in timer control bits 14:13; value 0 loads latches individually.
// R17 - A per-channel written flag is set by a buffer write and cleared by a load; load select 0 copies leave it set.
// R18 - Buffers and latches are sixteen bits and clear to zero at reset.
`ifndef CLL_CFG_SVH
`define CLL_CFG_SVH
`define CLL_MAX_CH 7
`define CLL_DW 16
`define CLL_OFF_TCTL 8'h00
`define CLL_OFF_CCTL 8'h04
`define CLL_OFF_CBUF 8'h20
`define CLL_OFF_LATCH 8'h40
`define CLL_OFF_WFLAG 8'h5c
`define CLL_GRP_LSB 13
`define CLL_MODE_LSB 4
`define CLL_LLS_LSB 9
`define CLL_RST_WORD 16'h0000
`define CLL_RESP_OKAY 2'b00
`define CLL_RESP_SLVERR 2'b10
`endif

// ===== rtl/cll_pkg.sv
// Types of the compare latch loader.
// Assumes cll_cfg.svh for the channel count and word width.
`include "cll_cfg.svh"
package cll_pkg;
    typedef logic [`CLL_DW-1:0] cll_word_t;
    typedef logic [`CLL_MAX_CH-1:0][`CLL_DW-1:0] cll_words_t;
    typedef enum logic [1:0] {
        CLL_LOAD_IMM = 2'b00,
        CLL_LOAD_ZERO = 2'b01,
        CLL_LOAD_ZERO_PER = 2'b10,
        CLL_LOAD_OWN = 2'b11
    } cll_lls_t;
    typedef enum logic [1:0] {
        CLL_HALT = 2'b00,
        CLL_UP = 2'b01,
        CLL_CONT = 2'b10,
        CLL_UPDOWN = 2'b11
    } cll_mode_t;
    typedef struct packed {
        cll_words_t cbuf;
        cll_words_t latch;
        logic [`CLL_MAX_CH-1:0][1:0] lls;
        logic [1:0] grp;
        logic [`CLL_MAX_CH-1:0] wflag;
        logic [`CLL_MAX_CH-1:0] equal;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cll_state_t;
endpackage

// ===== rtl/compare_latch_loader.sv
// Double-buffered compare latch loading for up to seven timer channels, AXI4-Lite slave.
// Assumes count value and count mode come from the counter core on the same clock.
`timescale 1ns/100ps
`include "cll_cfg.svh"
module compare_latch_loader
    import cll_pkg::*;
#(
    parameter int NUM_CH = `CLL_MAX_CH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`CLL_DW-1:0] count_value,
    input wire logic [1:0] count_mode,
    output cll_words_t compare_latch,
    output logic [`CLL_MAX_CH-1:0] compare_equal
);
    cll_state_t st_ff;
    cll_state_t nxt_st;

    // A small part cannot form triples, and its full group is channels 0 to 2.
    function automatic logic [1:0] grp_eff(input logic [1:0] g);
        grp_eff = (NUM_CH <= 3 && g == 2'd2) ? 2'd1 : g; // R14
    endfunction

    function automatic logic [2:0] leader(input logic [2:0] ch, input logic [1:0] g);
        logic [2:0] m1;
        m1 = ch - 3'd1;
        case (g)
            2'd0: leader = ch; // R16
            2'd1: leader = (ch == 3'd0) ? 3'd0 : {m1[2:1], 1'b1}; // R7
            2'd2: leader = (ch == 3'd0) ? 3'd0 : ((ch <= 3'd3) ? 3'd1 : 3'd4); // R7
            default: leader = 3'd0; // R7
        endcase
    endfunction

    function automatic logic [2:0] sel_src(input logic [2:0] ch, input logic [1:0] g);
        sel_src = (g == 2'd3) ? 3'd1 : leader(ch, g); // R8 R9 R13
    endfunction

    // Returns hit in bit 3 and the channel index below it.
    function automatic logic [3:0] dec_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        dec_idx = {(a[1:0] == 2'b00) && (a >= base) && (d[7:2] < NUM_CH), d[4:2]};
    endfunction

    function automatic cll_word_t wr16(input cll_word_t old, input logic [31:0] d,
                                       input logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb begin
        logic [3:0] wc;
        logic [3:0] wb;
        logic [3:0] rc;
        logic [3:0] rb;
        logic [3:0] rl;
        logic [1:0] g;
        logic [2:0] src;
        logic [1:0] sel;
        logic ev;
        logic complete;
        logic do_wr;
        logic [`CLL_MAX_CH-1:0] buf_wr;
        cll_word_t wval;
        nxt_st = st_ff;
        buf_wr = '0;
        wval = `CLL_RST_WORD;
        rc = '0;
        rb = '0;
        rl = '0;
        src = '0;
        sel = '0;
        ev = 1'b0;
        complete = 1'b0;
        g = grp_eff(st_ff.grp);
        if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        wc = dec_idx(st_ff.awaddr, `CLL_OFF_CCTL);
        wb = dec_idx(st_ff.awaddr, `CLL_OFF_CBUF);
        // Latch loads use the state before this cycle's write, so a write
        // landing on a load edge is kept for the next load.
        for (int i = 0; i < NUM_CH; i++) begin
            src = sel_src(3'(i), g);
            sel = st_ff.lls[src];
            case (cll_mode_t'(count_mode)) // R15
                CLL_HALT: ev = 1'b0;
                CLL_UP, CLL_CONT: ev = (sel == CLL_LOAD_OWN) ? (count_value == st_ff.latch[i])
                                                             : (count_value == '0);
                default: ev = (sel == CLL_LOAD_OWN) ? (count_value == st_ff.latch[i]) // R6
                            : ((count_value == '0) ||
                               (sel == CLL_LOAD_ZERO_PER && count_value == st_ff.latch[0])); // R5
            endcase
            complete = 1'b1;
            for (int j = 0; j < NUM_CH; j++) begin
                if (leader(3'(j), g) == leader(3'(i), g) && !st_ff.wflag[j]) begin
                    complete = 1'b0; // R10
                end
            end
            if (sel != CLL_LOAD_IMM && ev &&
                (g == 2'd0 || sel == CLL_LOAD_OWN || complete)) begin // R4 R10 R12
                nxt_st.latch[i] = st_ff.cbuf[i]; // R2
                nxt_st.wflag[i] = 1'b0; // R17
            end
        end
        if (do_wr) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `CLL_RESP_OKAY;
            if (st_ff.awaddr == `CLL_OFF_TCTL) begin
                if (st_ff.wstrb[1]) begin
                    nxt_st.grp = st_ff.wdata[`CLL_GRP_LSB+1:`CLL_GRP_LSB]; // R16
                end
            end else if (wc[3]) begin
                if (st_ff.wstrb[1]) begin
                    nxt_st.lls[wc[2:0]] = st_ff.wdata[`CLL_LLS_LSB+1:`CLL_LLS_LSB];
                end
            end else if (wb[3]) begin
                wval = wr16(st_ff.cbuf[wb[2:0]], st_ff.wdata, st_ff.wstrb);
                nxt_st.cbuf[wb[2:0]] = wval; // R2
                buf_wr[wb[2:0]] = 1'b1;
            end else begin
                nxt_st.bresp = `CLL_RESP_SLVERR;
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (buf_wr[i]) begin
                // Equal data still counts: the flag is set on any write.
                nxt_st.wflag[i] = 1'b1; // R11 R17
                if (st_ff.lls[sel_src(3'(i), g)] == CLL_LOAD_IMM) begin
                    nxt_st.latch[i] = wval; // R3
                end
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (i == 0) begin
                nxt_st.equal[i] = count_value >= st_ff.latch[i]; // R1
            end else begin
                nxt_st.equal[i] = count_value == st_ff.latch[i]; // R1
            end
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rvalid) begin
            rc = dec_idx(s_axi_araddr, `CLL_OFF_CCTL);
            rb = dec_idx(s_axi_araddr, `CLL_OFF_CBUF);
            rl = dec_idx(s_axi_araddr, `CLL_OFF_LATCH);
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `CLL_RESP_OKAY;
            nxt_st.rdata = '0;
            if (s_axi_araddr == `CLL_OFF_TCTL) begin
                nxt_st.rdata[`CLL_GRP_LSB+1:`CLL_GRP_LSB] = st_ff.grp;
                nxt_st.rdata[`CLL_MODE_LSB+1:`CLL_MODE_LSB] = count_mode;
            end else if (rc[3]) begin
                nxt_st.rdata[`CLL_LLS_LSB+1:`CLL_LLS_LSB] = st_ff.lls[rc[2:0]];
            end else if (rb[3]) begin
                nxt_st.rdata[`CLL_DW-1:0] = st_ff.cbuf[rb[2:0]];
            end else if (rl[3]) begin
                nxt_st.rdata[`CLL_DW-1:0] = st_ff.latch[rl[2:0]];
            end else if (s_axi_araddr == `CLL_OFF_WFLAG) begin
                nxt_st.rdata[`CLL_MAX_CH-1:0] = st_ff.wflag;
            end else begin
                nxt_st.rresp = `CLL_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0; // R18
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign compare_latch = st_ff.latch;
    assign compare_equal = st_ff.equal;
endmodule

// ===== testbench/cll_counter_model.sv
// Counter core stand-in: drives the count value and the count mode.
// Assumes the bench picks mode and period; all four count modes are modelled.
`timescale 1ns/100ps
module cll_counter_model
    import cll_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] mode_sel,
    input wire logic [15:0] period,
    output logic [15:0] count_value,
    output logic [1:0] count_mode
);
    logic [15:0] cnt_ff;
    logic down_ff;
    assign count_value = cnt_ff;
    assign count_mode = mode_sel;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 16'h0;
            down_ff <= 1'b0;
        end else begin
            case (mode_sel)
                2'h1: cnt_ff <= (cnt_ff >= period) ? 16'h0 : cnt_ff + 16'h1;
                2'h2: cnt_ff <= cnt_ff + 16'h1;
                2'h3: begin
                    // Turns at the period and at zero, so each end is seen once.
                    if (!down_ff && cnt_ff >= period) begin
                        down_ff <= 1'b1;
                        cnt_ff <= cnt_ff - 16'h1;
                    end else if (down_ff && cnt_ff == 16'h0) begin
                        down_ff <= 1'b0;
                        cnt_ff <= 16'h1;
                    end else begin
                        cnt_ff <= down_ff ? cnt_ff - 16'h1 : cnt_ff + 16'h1;
                    end
                end
                default: cnt_ff <= cnt_ff;
            endcase
        end
    end
endmodule

// ===== testbench/cll_props.sv
// Port checker for the compare latch loader.
// Assumes it is bound into every loader instance.
`timescale 1ns/100ps
`include "cll_cfg.svh"
module cll_props
    import cll_pkg::*;
#(
    parameter int NUM_CH = 7
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [`CLL_DW-1:0] count_value,
    input wire logic [1:0] count_mode,
    input wire cll_words_t compare_latch,
    input wire logic [`CLL_MAX_CH-1:0] compare_equal
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_EQ0: assert property ($past(aresetn) |-> compare_equal[0] ==
        ($past(count_value) >= $past(compare_latch[0]))) else $error("equal 0 wrong");
    AST_EQ1: assert property ($past(aresetn) |-> compare_equal[1] ==
        ($past(count_value) == $past(compare_latch[1]))) else $error("equal 1 wrong");
    AST_RST: assert property (!$past(aresetn) |-> compare_latch == '0)
        else $error("latch not cleared");
    AST_HALT: assert property (count_mode == 2'h0 && !$past(s_axi_wvalid)
        |=> $stable(compare_latch)) else $error("latch moved while halted");
    AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
    AST_RONE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_BBLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready during response");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid);
    cover property (compare_equal[0]);
endmodule
bind compare_latch_loader cll_props #(.NUM_CH(NUM_CH)) u_props (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .count_value(count_value), .count_mode(count_mode),
    .compare_latch(compare_latch), .compare_equal(compare_equal));

// ===== testbench/test_compare_latch_loader.sv
// Bench for the compare latch loader: bus tasks, counter model, scenarios.
// Assumes the checker binds itself; the counter halts between load runs.
`timescale 1ns/100ps
`include "cll_cfg.svh"
module test_compare_latch_loader
    import cll_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, cmode, msel, rsp;
    logic [15:0] cnt, per;
    logic [6:0] eq;
    cll_words_t lat;
    int error_cnt = 0;
    int comparisons = 0;
    compare_latch_loader uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .count_value(cnt), .count_mode(cmode),
        .compare_latch(lat), .compare_equal(eq));
    cll_counter_model u_cnt (.aclk(aclk), .aresetn(aresetn), .mode_sel(msel),
        .period(per), .count_value(cnt), .count_mode(cmode));
    task automatic wrap_up;
        $display("Counts: %0d compared, %0d wrong", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200) begin
            $display("Error wait expected done seen timeout");
            error_cnt++;
            wrap_up;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        comparisons++;
        if (act !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            tick(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        bready <= 1'b1;
        do tick(n); while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            tick(n);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                rready <= 1'b1;
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
        got = rdata;
        rsp = rresp;
    endtask
    // Runs the counter in mode m until the loader sees count v, then halts it again.
    task automatic run_to(input logic [1:0] m, input logic [15:0] v);
        int n;
        n = 0;
        msel <= m;
        do tick(n); while (!(cnt == v && cmode == m));
        tick(n);
        msel <= 2'h0;
        tick(n);
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, msel} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'h3;
        per = 16'h0010;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CLL_OFF_LATCH + 8'h0c);
        chk("latch3 reset", 32'h0, got);
        rd(8'h60);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        wr(`CLL_OFF_LATCH, 32'h1);
        chk("latch write resp", 32'h2, {30'h0, rsp});
        $display("Test reset and map done");
        wr(`CLL_OFF_CBUF + 8'h08, 32'h1234);
        chk("latch2 immediate", 32'h1234, {16'h0, lat[2]});
        wr(`CLL_OFF_CCTL + 8'h04, 32'h0200);
        wr(`CLL_OFF_CBUF + 8'h04, 32'h0055);
        chk("latch1 halted", 32'h0, {16'h0, lat[1]});
        run_to(2'h1, 16'h0);
        chk("latch1 at zero", 32'h55, {16'h0, lat[1]});
        $display("Test single loads done");
        wr(`CLL_OFF_TCTL, 32'h2000);
        wr(`CLL_OFF_CCTL + 8'h0c, 32'h0200);
        wr(`CLL_OFF_CBUF + 8'h10, 32'h0444);
        chk("latch4 not immediate", 32'h0, {16'h0, lat[4]});
        run_to(2'h1, 16'h0);
        chk("latch4 waits for pair", 32'h0, {16'h0, lat[4]});
        wr(`CLL_OFF_CBUF + 8'h0c, 32'h0333);
        run_to(2'h1, 16'h0);
        chk("latch3 pair", 32'h333, {16'h0, lat[3]});
        chk("latch4 pair", 32'h444, {16'h0, lat[4]});
        wr(`CLL_OFF_CBUF + 8'h14, 32'h0555);
        chk("latch5 other pair", 32'h555, {16'h0, lat[5]});
        $display("Test pair groups done");
        wr(`CLL_OFF_CBUF + 8'h08, 32'h2222);
        run_to(2'h1, 16'h0);
        chk("latch2 waits for ch1", 32'h1234, {16'h0, lat[2]});
        wr(`CLL_OFF_CBUF + 8'h04, 32'h0055);
        run_to(2'h1, 16'h0);
        chk("latch2 after same data", 32'h2222, {16'h0, lat[2]});
        $display("Test rewrite done");
        wr(`CLL_OFF_TCTL, 32'h4000);
        wr(`CLL_OFF_CBUF + 8'h14, 32'h0008);
        wr(`CLL_OFF_CBUF, 32'h000c);
        wr(`CLL_OFF_CCTL + 8'h10, 32'h0600);
        wr(`CLL_OFF_CBUF + 8'h14, 32'h0003);
        chk("latch5 triple held", 32'h8, {16'h0, lat[5]});
        run_to(2'h2, 16'h0008);
        chk("latch5 at own value", 32'h3, {16'h0, lat[5]});
        $display("Test triple own load done");
        wr(`CLL_OFF_TCTL, 32'h6000);
        wr(`CLL_OFF_CCTL + 8'h04, 32'h0400);
        for (int i = 0; i < 7; i++) begin
            wr(`CLL_OFF_CBUF + 8'(4 * i), 32'h0f00 + 32'(i));
        end
        chk("latch0 ignores own select", 32'hc, {16'h0, lat[0]});
        chk("latch6 before event", 32'h0, {16'h0, lat[6]});
        run_to(2'h3, 16'h000c);
        chk("latch0 at period", 32'hf00, {16'h0, lat[0]});
        chk("latch6 all grouped", 32'hf06, {16'h0, lat[6]});
        $display("Test full group done");
        wrap_up;
    end
endmodule
